// [rtl/nsc_defines.svh]
`ifndef NSC_DEFINES_SVH
`define NSC_DEFINES_SVH
`define NSC_OFS_CTRL 8'h84
`define NSC_OFS_DATA 8'h88
`define NSC_CTRL_RESET 8'h00
`define NSC_BIT_CLEAR 0
`define NSC_BIT_REWIND 1
`define NSC_BIT_FLUSH 2
`define NSC_BIT_FREEZE 3
`define NSC_BIT_HISEL 4
`define NSC_BIT_STGO 6
`define NSC_BIT_STRES 7
`define NSC_MARK_LO 24'h80_0000
`define NSC_MARK_HI 24'hC0_0000
`define NSC_FLUSH_THRESH 8'h80
`endif

// [rtl/nsc_entry_ram.sv]
`timescale 1ns/10ps
`default_nettype none
// 32 x 24 entry store, one write port and two asynchronous read ports
module nsc_entry_ram #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic i_core_clk,
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr_a,
    output logic [WIDTH-1:0] o_rdata_a,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr_b,
    output logic [WIDTH-1:0] o_rdata_b
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata_a = mem[i_raddr_a];
    assign o_rdata_b = mem[i_raddr_b];
endmodule
`default_nettype wire

// [rtl/nsc_pkg.sv]
package nsc_pkg;
    typedef enum logic [1:0] {
        NSC_IDLE,
        NSC_FLUSH,
        NSC_CLEAR,
        NSC_TEST
    } nsc_mode_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } nsc_bus_t;

    typedef struct packed {
        nsc_mode_t mode;
        logic [4:0] idx;
        logic [255:0] rt;
        logic [31:0] data;
        logic [4:0] rptr;
        logic clr_pend;
        logic freeze;
        logic hisel;
        logic stgo;
        logic stres;
        logic nearfull;
        logic st_fail;
    } nsc_state_t;
endpackage

// [rtl/nsc_stats.sv]
// How it works
// [R01] software pulses clear during init so all counters start at zero
// [R02] thirty-two 8-bit live counters, each counting its own event
// [R03] any live counter at threshold flushes all 32 into store entries
// [R04] store entry reaching watermark raises the near-full flag
// [R05] control bit 4 picks watermark 24'h800000 or 24'hC00000
// [R06] rewind bit resets pointer, presents entry 0, clears it, reads 0
// [R07] each data port read while idle with no clear pending advances pointer, loads and clears next entry
// [R08] software rewinds then reads the data port 32 times in order
// [R09] counting continues during readout so no event is lost
// [R10] clear bit wipes the store; live counters keep counting during clear, so no event is lost
// [R11] freeze bit stops all counting
// [R12] forced flush bit moves live counts into the store at once
// [R13] self-test go starts store test only in diagnostic mode
// [R14] self-test result reads 0 pass, 1 fail; a control write clears it unless a result lands that cycle
// [R15] data port returns index in 31:24 and value in 23:0
// [R16] the store holds 32 counters of 24 bits
// [R17] software must read counters out before any overflows after warning
// [R18] flush threshold leaves room so live counters never wrap
// [R19] near-full stays until cleared, re-raised by later flushes
`timescale 1ns/10ps
`default_nettype none
`include "nsc_defines.svh"
module nsc_stats
    import nsc_pkg::*;
#(
    parameter int NUM_EVT = 32,
    parameter int RT_W = 8,
    parameter int ENT_W = 24
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_EVT-1:0] i_event,
    input wire logic i_diagnostic_mode_mode,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_nearfull_flag,
    input wire logic i_nearfull_clr
);
    nsc_state_t s_q, s_d;
    nsc_bus_t bus;
    logic we;
    logic [4:0] waddr;
    logic [ENT_W-1:0] wdata, ram_flush, ram_read;
    logic ctrl_wr, data_rd;
    logic [4:0] rd_addr;
    logic [23:0] mark;

    assign bus = '{rd: i_reg_rd, wr: i_reg_wr, addr: i_reg_addr,
                   wdata: i_reg_wdata};

    function automatic logic [7:0] rt_get(input logic [255:0] v,
                                          input logic [4:0] i);
        rt_get = v[i*8 +: 8];
    endfunction

    nsc_entry_ram #(.WIDTH(ENT_W), .DEPTH(NUM_EVT)) u_ram ( // R16
        .i_core_clk(i_core_clk),
        .i_we(we),
        .i_waddr(waddr),
        .i_wdata(wdata),
        .i_raddr_a(s_q.idx),
        .o_rdata_a(ram_flush),
        .i_raddr_b(rd_addr),
        .o_rdata_b(ram_read)
    );

    assign ctrl_wr = bus.wr && bus.addr == `NSC_OFS_CTRL;
    assign data_rd = bus.rd && bus.addr == `NSC_OFS_DATA;
    // entry to show next: 0 on rewind, else the one after the pointer
    assign rd_addr = (ctrl_wr && bus.wdata[`NSC_BIT_REWIND]) ? 5'd0
        : s_q.rptr + 5'd1;
    assign mark = s_q.hisel ? `NSC_MARK_HI : `NSC_MARK_LO; // R05

    always_comb begin
        logic [4:0] k;
        logic [7:0] cnt;
        logic [ENT_W-1:0] sum;
        logic fl_hit;
        logic st_done;
        k = '0;
        st_done = 1'b0;
        cnt = '0;
        sum = '0;
        fl_hit = 1'b0;
        s_d = s_q;
        we = 1'b0;
        waddr = s_q.idx;
        wdata = '0;
        for (int i = 0; i < NUM_EVT; i++) begin
            if (rt_get(s_q.rt, 5'(i)) >= `NSC_FLUSH_THRESH) begin
                fl_hit = 1'b1; // R03 R18
            end
        end
        case (s_q.mode)
            NSC_FLUSH: begin
                cnt = rt_get(s_q.rt, s_q.idx);
                sum = ram_flush + {16'h0000, cnt}; // R03
                we = 1'b1;
                wdata = sum;
                s_d.rt[s_q.idx*8 +: 8] = 8'h00;
                if (sum >= mark) begin
                    s_d.nearfull = 1'b1; // R04 R19
                end
                s_d.idx = s_q.idx + 5'd1;
                if (s_q.idx == 5'(NUM_EVT-1)) begin
                    s_d.mode = NSC_IDLE;
                end
            end
            NSC_CLEAR: begin
                we = 1'b1; // R10
                wdata = '0;
                s_d.idx = s_q.idx + 5'd1;
                if (s_q.idx == 5'(NUM_EVT-1)) begin
                    s_d.mode = NSC_IDLE;
                    s_d.clr_pend = 1'b0;
                end
            end
            NSC_TEST: begin
                // write-then-read pattern check of every entry, leaves zero
                if (!s_q.stgo) begin
                    we = 1'b1;
                    wdata = {19'h0, s_q.idx} ^ 24'hA5A5A5;
                    s_d.stgo = 1'b1;
                end else begin
                    if (ram_flush != ({19'h0, s_q.idx} ^ 24'hA5A5A5)) begin
                        s_d.st_fail = 1'b1;
                    end
                    we = 1'b1;
                    wdata = '0;
                    s_d.stgo = 1'b0;
                    s_d.idx = s_q.idx + 5'd1;
                    if (s_q.idx == 5'(NUM_EVT-1)) begin
                        s_d.mode = NSC_IDLE;
                        s_d.stres = s_d.st_fail; // R14
                        st_done = 1'b1;
                    end
                end
            end
            default: begin
                s_d.idx = '0;
                if (s_q.clr_pend) begin
                    s_d.mode = NSC_CLEAR;
                end else if (fl_hit) begin
                    s_d.mode = NSC_FLUSH;
                end
            end
        endcase
        // live counters keep counting during readout and flush
        for (int i = 0; i < NUM_EVT; i++) begin
            if (i_event[i] && !s_q.freeze) begin // R02 R09 R11
                s_d.rt[i*8 +: 8] = s_d.rt[i*8 +: 8] + 8'h01;
            end
        end
        if (s_q.mode == NSC_IDLE && !s_q.clr_pend && !we) begin
            if (data_rd) begin // R07
                k = s_q.rptr + 5'd1;
                s_d.rptr = k;
                s_d.data = {3'h0, k, ram_read}; // R15
                we = 1'b1;
                waddr = k;
                wdata = '0;
            end
        end
        if (ctrl_wr) begin
            s_d.freeze = bus.wdata[`NSC_BIT_FREEZE]; // R11
            s_d.hisel = bus.wdata[`NSC_BIT_HISEL];
            // a result landing in this cycle wins over the write clear
            if (!st_done) begin
                s_d.stres = 1'b0; // R14
            end
            if (bus.wdata[`NSC_BIT_CLEAR]) begin
                s_d.clr_pend = 1'b1; // R10
            end
            if (bus.wdata[`NSC_BIT_FLUSH] && s_q.mode == NSC_IDLE
                && !s_q.clr_pend) begin
                s_d.mode = NSC_FLUSH; // R12
                s_d.idx = '0;
            end
            if (bus.wdata[`NSC_BIT_STGO] && i_diagnostic_mode_mode
                && s_q.mode == NSC_IDLE && !s_q.clr_pend) begin
                s_d.mode = NSC_TEST; // R13
                s_d.idx = '0;
                s_d.stgo = 1'b0;
                s_d.st_fail = 1'b0;
            end
            if (bus.wdata[`NSC_BIT_REWIND]) begin
                s_d.rptr = '0; // R06
                s_d.data = '0;
            end
        end
        if (ctrl_wr && bus.wdata[`NSC_BIT_REWIND] && s_q.mode == NSC_IDLE
            && !we) begin
            // present entry 0 and empty it
            s_d.data = {8'h00, ram_read}; // R06
            we = 1'b1;
            waddr = '0;
            wdata = '0;
        end
        if (i_nearfull_clr && !(s_q.mode == NSC_FLUSH && sum >= mark)) begin
            s_d.nearfull = 1'b0; // R19
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        o_reg_rdata = '0;
        if (bus.addr == `NSC_OFS_CTRL) begin
            o_reg_rdata[`NSC_BIT_STRES] = s_q.stres;
            o_reg_rdata[`NSC_BIT_STGO] = s_q.mode == NSC_TEST;
            o_reg_rdata[`NSC_BIT_HISEL] = s_q.hisel;
            o_reg_rdata[`NSC_BIT_FREEZE] = s_q.freeze;
            o_reg_rdata[`NSC_BIT_CLEAR] = s_q.clr_pend;
        end else if (bus.addr == `NSC_OFS_DATA) begin
            o_reg_rdata = s_q.data;
        end
    end
    assign o_nearfull_flag = s_q.nearfull;

    sequence nsc_flush_start;
        $rose(s_q.mode == NSC_FLUSH);
    endsequence
    sequence nsc_flush_done;
        ##[1:40] s_q.mode != NSC_FLUSH;
    endsequence

    a_freeze_holds: assert property (@(posedge i_core_clk) // R11
        disable iff (!i_rst_n) s_q.freeze && s_q.mode == NSC_IDLE
        |=> s_q.rt == $past(s_q.rt)) else $error("count while frozen");
    a_rewind_zero: assert property (@(posedge i_core_clk) // R06
        disable iff (!i_rst_n) ctrl_wr && bus.wdata[`NSC_BIT_REWIND]
        |=> s_q.rptr == '0 && s_q.data[31:24] == 8'h00)
        else $error("rewind failed");
    a_read_adv: assert property (@(posedge i_core_clk) // R07
        disable iff (!i_rst_n) data_rd && s_q.mode == NSC_IDLE
        && !s_q.clr_pend
        |=> s_q.rptr == $past(s_q.rptr) + 5'd1
        && s_q.data[31:24] == {3'h0, s_q.rptr}) else $error("no advance");
    a_no_wrap: assert property (@(posedge i_core_clk) // R18
        disable iff (!i_rst_n) rt_get(s_q.rt, 5'd0) != 8'hFF)
        else $error("live counter near wrap");
    a_flush_len: assert property (@(posedge i_core_clk) // R03
        disable iff (!i_rst_n) nsc_flush_start |-> nsc_flush_done)
        else $error("flush hung");
    a_nf_sticky: assert property (@(posedge i_core_clk) // R19
        disable iff (!i_rst_n) s_q.nearfull && !i_nearfull_clr
        |=> s_q.nearfull) else $error("near-full dropped");
    a_test_gate: assert property (@(posedge i_core_clk) // R13
        disable iff (!i_rst_n) s_q.mode == NSC_IDLE && !i_diagnostic_mode_mode
        |=> s_q.mode != NSC_TEST) else $error("test without diagnostic_mode");
    a_clear_runs: assert property (@(posedge i_core_clk) // R10
        disable iff (!i_rst_n) s_q.clr_pend && s_q.mode == NSC_IDLE
        |=> s_q.mode == NSC_CLEAR) else $error("clear not started");
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import nsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] ev = 32'h0;
    logic diagnostic_mode = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic nf_flag;
    logic nf_clr = 1'b0;
    bit ev_on = 1'b0;
    bit frz = 1'b0;
    int unsigned tally [32];
    int unsigned expv [32];
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] q;

    nsc_stats nsc_stats_i (
        .i_core_clk(clk),
        .i_rst_n(rst_n),
        .i_event(ev),
        .i_diagnostic_mode_mode(diagnostic_mode),
        .i_reg_rd(rd),
        .i_reg_wr(wr),
        .i_reg_addr(addr),
        .i_reg_wdata(wdata),
        .o_reg_rdata(rdata),
        .o_nearfull_flag(nf_flag),
        .i_nearfull_clr(nf_clr)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    // random event traffic; the bench keeps its own count of every strobe it drives while frz is clear
    always @(posedge clk) begin
        logic [31:0] v;
        v = ev_on ? $urandom : 32'h0;
        ev <= v;
        nf_clr <= ev_on && ($urandom % 7 == 0);
        if (!frz) begin
            for (int k = 0; k < 32; k++) begin
                tally[k] += v[k];
            end
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input bit w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // poll the control register until the masked busy bits drop
    task automatic poll(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h84, 32'h0, q);
            n++;
        end while ((q[7:0] & m) != 8'h00 && n < 200);
        if ((q[7:0] & m) != 8'h00) begin
            errors++;
            complete_run();
        end
    endtask

    function automatic logic [31:0] port_word(input int i,
                                              input int unsigned c);
        return {i[7:0], c[23:0]};
    endfunction

    // one pass: count, flush, rewind, read all entries while counting goes on
    task automatic round(input bit fz);
        if (fz) begin
            bus(1'b1, 8'h84, 32'h08, q);
            frz = 1'b1;
        end
        ev_on = 1'b1;
        repeat (20 + $urandom % 60) @(posedge clk);
        ev_on = 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b1, 8'h84, fz ? 32'h0C : 32'h04, q);
        repeat (40) @(posedge clk);
        bus(1'b1, 8'h84, 32'h00, q);
        frz = 1'b0;
        expv = tally;
        tally = '{default: 0};
        bus(1'b1, 8'h84, 32'h02, q);
        ev_on = 1'b1;
        for (int i = 0; i < 32; i++) begin
            bus(1'b0, 8'h88, 32'h0, q);
            check(q, port_word(i, expv[i]));
        end
        ev_on = 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, nf_flag}, 32'h0);
    endtask

    initial begin
        tally = '{default: 0};
        void'($urandom(32'h46BEE94D));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h84, 32'h0, q);
        check(q, 32'h00);
        bus(1'b0, 8'h88, 32'h0, q);
        check(q, 32'h0);
        bus(1'b1, 8'h84, 32'h10, q);
        bus(1'b0, 8'h84, 32'h0, q);
        check(q, 32'h10);
        bus(1'b1, 8'h84, 32'h12, q);
        bus(1'b0, 8'h84, 32'h0, q);
        check(q, 32'h10);
        bus(1'b1, 8'h84, 32'h40, q);
        bus(1'b0, 8'h84, 32'h0, q);
        check(q, 32'h00);
        diagnostic_mode <= 1'b1;
        bus(1'b1, 8'h84, 32'h40, q);
        poll(8'h40);
        check(q, 32'h00);
        diagnostic_mode <= 1'b0;
        bus(1'b1, 8'h84, 32'h01, q);
        poll(8'h01);
        repeat (40) @(posedge clk);
        tally = '{default: 0};
        round(1'b1);
        for (int r = 0; r < 4; r++) begin
            round(1'b0);
        end
        complete_run();
    end
endmodule
`default_nettype wire
